/* hw/vsr_regs.sv */
// Purpose: status ports, sequencer index/data registers and sequencer timing
// Assumes: CLK_SYS is the sequencer master clock; timing inputs share it
// Notes: read data appears one cycle after the read strobe
`timescale 1ns/10ps
`include "vsr_params.svh"
module vsr_regs
	import vsr_pkg::*;
(
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// Host I/O port bus
	input wire logic [15:0] IO_ADDR,
	input wire logic IO_WR,
	input wire logic IO_RD,
	input wire logic [7:0] IO_WDATA,
	output logic [7:0] IO_RDATA,
	output logic IO_RVALID,
	// Miscellaneous output fields
	input wire logic [1:0] CLOCK_SEL,
	input wire logic PORT_BASE_SELECT,
	// Sense switch pins
	input wire logic [3:0] SENSE_SW,
	// CRT timing and retrace interrupt control
	input wire logic IN_VERTICAL_RETRACE,
	input wire logic DISPLAY_ENABLE,
	input wire logic RETRACE_IRQ_ENABLE,
	input wire logic RETRACE_IRQ_CLEAR,
	output logic RETRACE_IRQ_PENDING,
	// Sequencer timing
	output logic CHAR_CLK_EN,
	output logic SER_LOAD,
	output logic SEQ_RUNNING,
	output logic SCREEN_BLANK,
	output logic HOST_PRIORITY,
	// Ninth dot generation
	input wire logic [7:0] GLYPH_CODE,
	input wire logic LINE_GFX_EN,
	input wire logic DOT_EIGHT,
	output logic NINTH_DOT,
	// Host memory write path
	input wire logic MEM_WR,
	input wire logic MEM_USE_LATCH,
	input wire logic [7:0] MEM_WDATA,
	input wire logic [31:0] LATCH_DATA,
	output logic [3:0] PLANE_WE,
	output logic PLANE_SRC_LATCH,
	output logic [31:0] PLANE_WDATA
);

	vsr_state_s s_r;
	vsr_state_s s_nxt;

	logic idx_wr;
	logic data_wr;
	logic data_rd;
	logic dot_en;
	logic wrap;

	function automatic logic status_two_hit(input logic [15:0] a, input logic base);
		status_two_hit = base ? (a == `VSR_PORT_COLOR_A) : (a == `VSR_PORT_MONO_A);
	endfunction : status_two_hit

	function automatic logic sense_pick(input logic [3:0] sw, input logic [1:0] sel);
		sense_pick = sw[sel];
	endfunction : sense_pick

	assign idx_wr = IO_WR && (IO_ADDR == `VSR_PORT_INDEX);
	assign data_wr = IO_WR && (IO_ADDR == `VSR_PORT_DATA);
	assign data_rd = IO_RD && (IO_ADDR == `VSR_PORT_DATA);
	assign dot_en = s_r.run && (!s_r.clk[`VSR_BIT_HALVE] || s_r.half);
	assign wrap = dot_en && (s_r.dot == (s_r.clk[`VSR_BIT_EIGHT] ?
		`VSR_DOT_LAST8 : `VSR_DOT_LAST9));

	always_comb
	begin
		s_nxt = s_r;
		s_nxt.sw_m = SENSE_SW;
		s_nxt.sw_s = s_r.sw_m;
		s_nxt.vr_d = IN_VERTICAL_RETRACE;
		s_nxt.vr = IN_VERTICAL_RETRACE;
		s_nxt.inact = !DISPLAY_ENABLE;
		// Retrace interrupt: set wins over clear
		if (RETRACE_IRQ_CLEAR)
		begin
			s_nxt.irq = 1'b0;
		end
		if (RETRACE_IRQ_ENABLE && IN_VERTICAL_RETRACE && !s_r.vr_d)
		begin
			s_nxt.irq = 1'b1;
		end
		// Register writes; index holds until rewritten
		if (idx_wr)
		begin
			s_nxt.idx = IO_WDATA[2:0];
		end
		if (data_wr)
		begin
			unique case (s_r.idx)
				`VSR_IDX_RESET:
				begin
					s_nxt.rst = IO_WDATA[1:0];
				end
				`VSR_IDX_CLOCK:
				begin
					s_nxt.clk = IO_WDATA & `VSR_CLOCK_WMASK;
				end
				`VSR_IDX_MASK:
				begin
					s_nxt.mask = IO_WDATA[3:0];
				end
				default:
				begin
					s_nxt.rst = s_r.rst;
				end
			endcase
		end
		// Read answers; unmapped ports give no valid
		s_nxt.rvalid = 1'b0;
		s_nxt.rdata = 8'h00;
		if (IO_RD)
		begin
			if (IO_ADDR == `VSR_PORT_ISR0)
			begin
				s_nxt.rvalid = 1'b1;
				s_nxt.rdata[`VSR_BIT_PENDING] = s_r.irq;
				s_nxt.rdata[`VSR_BIT_SENSE] = sense_pick(s_r.sw_s, CLOCK_SEL);
			end
			else if (status_two_hit(IO_ADDR, PORT_BASE_SELECT))
			begin
				s_nxt.rvalid = 1'b1;
				s_nxt.rdata[`VSR_BIT_VR] = s_r.vr;
				s_nxt.rdata[`VSR_BIT_DE] = s_r.inact;
			end
			else if (IO_ADDR == `VSR_PORT_FEAT_RD || IO_ADDR == `VSR_PORT_ENABLE)
			begin
				s_nxt.rvalid = 1'b1;
			end
			else if (IO_ADDR == `VSR_PORT_INDEX)
			begin
				s_nxt.rvalid = 1'b1;
				s_nxt.rdata[2:0] = s_r.idx;
			end
			else if (data_rd)
			begin
				s_nxt.rvalid = 1'b1;
				unique case (s_r.idx)
					`VSR_IDX_RESET:
					begin
						s_nxt.rdata[1:0] = s_r.rst;
					end
					`VSR_IDX_CLOCK:
					begin
						s_nxt.rdata = s_r.clk;
						s_nxt.rdata[`VSR_BIT_ONE] = 1'b1;
					end
					`VSR_IDX_MASK:
					begin
						s_nxt.rdata[3:0] = s_r.mask;
					end
					default:
					begin
						s_nxt.rdata = 8'h00;
					end
				endcase
			end
		end
		// Sequencer dot and character timing
		s_nxt.char_en = 1'b0;
		s_nxt.load = 1'b0;
		if (s_r.run)
		begin
			s_nxt.half = !s_r.half;
		end
		if (dot_en)
		begin
			s_nxt.dot = wrap ? 4'h0 : s_r.dot + 4'h1;
		end
		if (wrap)
		begin
			s_nxt.char_en = 1'b1;
			s_nxt.chr = s_r.chr + 2'h1;
			// Bit 2 plays no part here
			s_nxt.load = s_r.clk[`VSR_BIT_FOURTH] ?
				(s_r.chr == `VSR_CHR_LAST) : 1'b1;
		end
		// Halt and restart
		if (!s_r.rst[`VSR_BIT_ASYNC_N])
		begin
			s_nxt.run = 1'b0;
		end
		else if (!s_r.rst[`VSR_BIT_SYNC_N])
		begin
			s_nxt.run = s_r.run && !wrap;
		end
		else
		begin
			s_nxt.run = 1'b1;
		end
		if (!s_nxt.run)
		begin
			s_nxt.half = 1'b0;
			s_nxt.dot = 4'h0;
			s_nxt.chr = 2'h0;
		end
		s_nxt.blank = s_r.clk[`VSR_BIT_SCREEN_OFF];
		s_nxt.ninth = !s_r.clk[`VSR_BIT_EIGHT] && LINE_GFX_EN && DOT_EIGHT &&
			GLYPH_CODE >= `VSR_LINE_GFX_LO && GLYPH_CODE <= `VSR_LINE_GFX_HI;
		// Host writes pass whatever the display is doing
		s_nxt.pwe = MEM_WR ? s_r.mask : 4'h0;
		s_nxt.src_latch = MEM_WR && MEM_USE_LATCH;
		if (MEM_WR)
		begin
			s_nxt.pdata = MEM_USE_LATCH ? LATCH_DATA : {4{MEM_WDATA}};
		end
	end

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			s_r <= '0;
			s_r.rst <= `VSR_RST_RESET;
			s_r.clk <= `VSR_RST_CLOCK;
			s_r.mask <= `VSR_RST_MASK;
		end
		else
		begin
			s_r <= s_nxt;
		end
	end

	assign IO_RDATA = s_r.rdata;
	assign IO_RVALID = s_r.rvalid;
	assign RETRACE_IRQ_PENDING = s_r.irq;
	assign CHAR_CLK_EN = s_r.char_en;
	assign SER_LOAD = s_r.load;
	assign SEQ_RUNNING = s_r.run;
	assign SCREEN_BLANK = s_r.blank;
	assign HOST_PRIORITY = s_r.blank;
	assign NINTH_DOT = s_r.ninth;
	assign PLANE_WE = s_r.pwe;
	assign PLANE_SRC_LATCH = s_r.src_latch;
	assign PLANE_WDATA = s_r.pdata;

	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);

	sequence s_eight_gap;
		!s_r.char_en [*7] ##1 s_r.char_en;
	endsequence

	a_irq_set_edge: assert property (
		(RETRACE_IRQ_ENABLE && IN_VERTICAL_RETRACE && !s_r.vr_d) |=> s_r.irq)
		else $error("retrace interrupt not raised");
	a_isr_pending_read: assert property (
		(IO_RD && IO_ADDR == `VSR_PORT_ISR0) |=>
		(IO_RVALID && IO_RDATA[`VSR_BIT_PENDING] == $past(s_r.irq)))
		else $error("pending bit read wrong");
	a_inactive_mirror: assert property (
		1'b1 |=> (s_r.inact == !$past(DISPLAY_ENABLE)))
		else $error("inactive bit not inverted enable");
	a_async_halt_now: assert property (
		!s_r.rst[`VSR_BIT_ASYNC_N] |=> (!s_r.run && s_r.dot == 4'h0))
		else $error("asynchronous clear did not halt");
	a_sync_halt_wrap: assert property (
		(s_r.rst == 2'h1 && wrap) |=> !s_r.run)
		else $error("synchronous clear did not halt at boundary");
	a_run_needs_both: assert property (
		$rose(s_r.run) |-> $past(s_r.rst) == 2'h3)
		else $error("sequencer started without both bits");
	a_blank_follows: assert property (
		s_r.clk[`VSR_BIT_SCREEN_OFF] |=> (SCREEN_BLANK && HOST_PRIORITY))
		else $error("screen off not blanking");
	a_fourth_load: assert property (
		(s_r.load && s_r.clk[`VSR_BIT_FOURTH]) |-> s_r.chr == 2'h0)
		else $error("fourth-load at wrong character");
	a_eight_dots: assert property (
		(s_r.char_en && s_r.clk[`VSR_BIT_EIGHT] && !s_r.clk[`VSR_BIT_HALVE] &&
		s_r.rst == 2'h3 && !data_wr) |-> (##1 s_eight_gap) or (##[1:7] data_wr))
		else $error("eight-dot character width wrong");
	a_half_dots: assert property (
		(s_r.char_en && s_r.clk[`VSR_BIT_EIGHT] && s_r.clk[`VSR_BIT_HALVE] &&
		s_r.rst == 2'h3 && !data_wr) |-> (##16 s_r.char_en) or (##[1:16] data_wr))
		else $error("halved dot clock width wrong");
	a_plane_mask: assert property (
		MEM_WR |=> PLANE_WE == $past(s_r.mask))
		else $error("plane enables differ from mask");
	a_latch_store: assert property (
		(MEM_WR && MEM_USE_LATCH) |=> (PLANE_SRC_LATCH && PLANE_WDATA == $past(LATCH_DATA)))
		else $error("latch data not stored");
	a_sense_read: assert property (
		(IO_RD && IO_ADDR == `VSR_PORT_ISR0) |=>
		(IO_RDATA[`VSR_BIT_SENSE] == $past(s_r.sw_s[CLOCK_SEL])))
		else $error("sense bit read wrong");
	a_status_two_read: assert property (
		(IO_RD && status_two_hit(IO_ADDR, PORT_BASE_SELECT)) |=>
		(IO_RVALID && IO_RDATA[`VSR_BIT_VR] == $past(s_r.vr) &&
		IO_RDATA[`VSR_BIT_DE] == $past(s_r.inact)))
		else $error("second status read wrong");
	a_index_hold: assert property (
		!idx_wr |=> s_r.idx == $past(s_r.idx))
		else $error("index changed without a write");
	a_load_rate: assert property (
		(s_r.char_en && !s_r.clk[`VSR_BIT_FOURTH] && !$past(data_wr)) |-> s_r.load)
		else $error("serializer load missed a character");
endmodule : vsr_regs

/* pkg/vsr_params.svh */
// Purpose: constants of the video status and sequencer register bank
// Assumes: 8-bit host I/O port bus, sequencer master clock is CLK_SYS
// Notes: reset values are plain defaults
// Overview of operation
// - Status-one bit 7 reads 1 while a vertical retrace interrupt is pending.
// - Status-one bit 4 returns the sense switch picked by the clock select.
// - Status-two retrace bit reads 1 during vertical retrace.
// - When enabled, an interrupt is raised at each vertical retrace start.
// - Status-two inactive bit is the inverted display enable, registered one cycle.
// - Host memory writes are accepted at any time in the frame.
// - Feature control and subsystem enable ports are wholly reserved.
// - Index port 0x03C4 selects the data register seen at 0x03C5.
// - Every sequencer data register is readable and writable.
// - Reset bit 1 at 0 clears and halts the sequencer synchronously.
// - Reset bit 0 at 0 clears and halts the sequencer at once.
// - Sequencer starts only when both reset bits are 1.
// - Clocking bit 5 blanks the screen and favours the host; syncs continue.
// - Serializer loads every character clock, or every fourth with bit 4.
// - Every-other-load bit 2 is ignored and treated as 0.
// - Clocking bit 3 halves the master clock to make the dot clock.
// - Clocking bit 0 selects 9-dot (0) or 8-dot (1) character clocks.
// - In 9-dot mode codes 0xC0-0xDF copy dot eight into dot nine.
// - Map mask bits 3-0 enable host writes into each plane.
// - With all planes enabled a write can store the data latches.
// - Unused bits are written 0 and read back as 0, except clocking bit 1, which reads back as 1.
// - Clock select codes 0 and 1 pick 25 or 28 MHz; others reserved.
// - Port base select places status-two at 0x03BA or 0x03DA.
`ifndef VSR_PARAMS_SVH
`define VSR_PARAMS_SVH
`define VSR_PORT_ISR0 16'h03c2
`define VSR_PORT_ENABLE 16'h03c3
`define VSR_PORT_INDEX 16'h03c4
`define VSR_PORT_DATA 16'h03c5
`define VSR_PORT_FEAT_RD 16'h03ca
`define VSR_PORT_MONO_A 16'h03ba
`define VSR_PORT_COLOR_A 16'h03da
`define VSR_IDX_RESET 3'h0
`define VSR_IDX_CLOCK 3'h1
`define VSR_IDX_MASK 3'h2
`define VSR_BIT_PENDING 7
`define VSR_BIT_SENSE 4
`define VSR_BIT_VR 3
`define VSR_BIT_DE 0
`define VSR_BIT_SYNC_N 1
`define VSR_BIT_ASYNC_N 0
`define VSR_BIT_SCREEN_OFF 5
`define VSR_BIT_FOURTH 4
`define VSR_BIT_HALVE 3
`define VSR_BIT_OTHER 2
`define VSR_BIT_ONE 1
`define VSR_BIT_EIGHT 0
`define VSR_RST_RESET 2'h3
`define VSR_RST_CLOCK 8'h00
`define VSR_RST_MASK 4'hf
`define VSR_CLOCK_WMASK 8'h3d
`define VSR_DOT_LAST8 4'h7
`define VSR_DOT_LAST9 4'h8
`define VSR_CHR_LAST 2'h3
`define VSR_LINE_GFX_LO 8'hc0
`define VSR_LINE_GFX_HI 8'hdf
`endif

/* pkg/vsr_pkg.sv */
// Purpose: types of the video status and sequencer register bank
// Assumes: constants come from vsr_params.svh
// Notes: all module state is one packed struct
package vsr_pkg;
	typedef struct packed {
		logic [3:0] sw_m;
		logic [3:0] sw_s;
		logic [2:0] idx;
		logic [1:0] rst;
		logic [7:0] clk;
		logic [3:0] mask;
		logic irq;
		logic vr_d;
		logic vr;
		logic inact;
		logic [7:0] rdata;
		logic rvalid;
		logic half;
		logic [3:0] dot;
		logic [1:0] chr;
		logic run;
		logic char_en;
		logic load;
		logic ninth;
		logic blank;
		logic [3:0] pwe;
		logic src_latch;
		logic [31:0] pdata;
	} vsr_state_s;
endpackage : vsr_pkg

/* bench/vsr_regs_bench.sv */
// Purpose: self-checking bench of the status and sequencer register bank
// Assumes: host strobes are one-cycle pulses driven at the falling edge
// Notes: clock selection changes are wrapped in a synchronous halt
`timescale 1ns/10ps
`include "vsr_params.svh"
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_mismatch++; $display("unexpected at %0t got %h expected %h", $time, (a), (e)); end end
module vsr_regs_bench;
	logic CLK_SYS = 1'b0, RST_N = 1'b0, IO_WR = 1'b0, IO_RD = 1'b0, IO_RVALID;
	logic [15:0] IO_ADDR = 16'h0000;
	logic [7:0] IO_WDATA = 8'h00, IO_RDATA, GLYPH_CODE = 8'h00, MEM_WDATA = 8'h00;
	logic [1:0] CLOCK_SEL = 2'h0;
	logic [3:0] SENSE_SW = 4'h5, PLANE_WE;
	logic PORT_BASE_SELECT = 1'b0, IN_VERTICAL_RETRACE = 1'b0, DISPLAY_ENABLE = 1'b1;
	logic RETRACE_IRQ_ENABLE = 1'b0, RETRACE_IRQ_CLEAR = 1'b0, RETRACE_IRQ_PENDING;
	logic CHAR_CLK_EN, SER_LOAD, SEQ_RUNNING, SCREEN_BLANK, HOST_PRIORITY, NINTH_DOT;
	logic LINE_GFX_EN = 1'b1, DOT_EIGHT = 1'b1, MEM_WR = 1'b0, MEM_USE_LATCH = 1'b0;
	logic PLANE_SRC_LATCH;
	logic [31:0] LATCH_DATA = 32'h0000_0000, PLANE_WDATA;
	int n_mismatch = 0, checked = 0;
	logic [7:0] rd;
	logic rv;
	int g;
	vsr_regs i_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N), .IO_ADDR(IO_ADDR), .IO_WR(IO_WR),
		.IO_RD(IO_RD), .IO_WDATA(IO_WDATA), .IO_RDATA(IO_RDATA), .IO_RVALID(IO_RVALID),
		.CLOCK_SEL(CLOCK_SEL), .PORT_BASE_SELECT(PORT_BASE_SELECT), .SENSE_SW(SENSE_SW),
		.IN_VERTICAL_RETRACE(IN_VERTICAL_RETRACE), .DISPLAY_ENABLE(DISPLAY_ENABLE),
		.RETRACE_IRQ_ENABLE(RETRACE_IRQ_ENABLE), .RETRACE_IRQ_CLEAR(RETRACE_IRQ_CLEAR),
		.RETRACE_IRQ_PENDING(RETRACE_IRQ_PENDING), .CHAR_CLK_EN(CHAR_CLK_EN),
		.SER_LOAD(SER_LOAD), .SEQ_RUNNING(SEQ_RUNNING), .SCREEN_BLANK(SCREEN_BLANK),
		.HOST_PRIORITY(HOST_PRIORITY), .GLYPH_CODE(GLYPH_CODE), .LINE_GFX_EN(LINE_GFX_EN),
		.DOT_EIGHT(DOT_EIGHT), .NINTH_DOT(NINTH_DOT), .MEM_WR(MEM_WR),
		.MEM_USE_LATCH(MEM_USE_LATCH), .MEM_WDATA(MEM_WDATA), .LATCH_DATA(LATCH_DATA),
		.PLANE_WE(PLANE_WE), .PLANE_SRC_LATCH(PLANE_SRC_LATCH), .PLANE_WDATA(PLANE_WDATA));
	initial
	begin
		forever #10 CLK_SYS = ~CLK_SYS;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge CLK_SYS);
	endtask : tick
	task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
		IO_ADDR = a;
		IO_WDATA = d;
		IO_WR = 1'b1;
		tick(1);
		IO_WR = 1'b0;
		tick(1);
	endtask : io_wr
	task automatic io_rd(input logic [15:0] a);
		IO_ADDR = a;
		IO_RD = 1'b1;
		tick(1);
		IO_RD = 1'b0;
		rv = IO_RVALID;
		rd = IO_RDATA;
		tick(1);
	endtask : io_rd
	task automatic chk_rd(input logic [15:0] a, input logic [7:0] m, input logic [7:0] e);
		io_rd(a);
		`CHK(rv, 1'b1)
		`CHK(rd & m, e)
	endtask : chk_rd
	task automatic seq_wr(input logic [2:0] i, input logic [7:0] d);
		io_wr(`VSR_PORT_INDEX, {5'h00, i});
		io_wr(`VSR_PORT_DATA, d);
	endtask : seq_wr
	task automatic seq_rd(input logic [2:0] i, input logic [7:0] m, input logic [7:0] e);
		io_wr(`VSR_PORT_INDEX, {5'h00, i});
		chk_rd(`VSR_PORT_DATA, m, e);
	endtask : seq_rd
	// Synchronous halt, then wait for the character boundary
	task automatic halt_sync;
		seq_wr(`VSR_IDX_RESET, 8'h01);
		while (SEQ_RUNNING)
		begin
			tick(1);
		end
	endtask : halt_sync
	// Halt, change clocking, release
	task automatic clk_mode(input logic [7:0] v);
		halt_sync();
		seq_wr(`VSR_IDX_CLOCK, v);
		seq_wr(`VSR_IDX_RESET, 8'h03);
	endtask : clk_mode
	// Cycles between two pulses of a timing output
	task automatic gap(input bit ser, output int n);
		int k;
		k = 0;
		while (!(ser ? SER_LOAD : CHAR_CLK_EN) && k < 200)
		begin
			tick(1);
			k++;
		end
		n = 0;
		do
		begin
			tick(1);
			n++;
		end while (!(ser ? SER_LOAD : CHAR_CLK_EN) && n < 200);
	endtask : gap
	task automatic mem_wr(input logic lat);
		MEM_USE_LATCH = lat;
		MEM_WR = 1'b1;
		tick(1);
		MEM_WR = 1'b0;
	endtask : mem_wr
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (20000) @(posedge CLK_SYS);
		n_mismatch++;
		end_sim();
	end
	localparam logic [7:0] MODE [7] = '{8'h00, 8'h01, 8'h09, 8'h08, 8'h11, 8'h04, 8'h05};
	localparam int CGAP [7] = '{9, 8, 16, 18, 8, 9, 8};
	localparam int SGAP [7] = '{9, 8, 16, 18, 32, 9, 8};
	localparam logic [7:0] CODE [4] = '{8'hbf, 8'hc0, 8'hdf, 8'he0};
	localparam logic NINE [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
	initial
	begin
		tick(6);
		RST_N = 1'b1;
		tick(2);
		seq_rd(`VSR_IDX_RESET, 8'h03, 8'h03);
		seq_rd(`VSR_IDX_CLOCK, 8'h3f, 8'h02);
		seq_rd(`VSR_IDX_MASK, 8'h0f, 8'h0f);
		chk_rd(`VSR_PORT_INDEX, 8'h07, 8'h02);
		seq_wr(`VSR_IDX_MASK, 8'h05);
		io_wr(`VSR_PORT_ENABLE, 8'hff);
		io_wr(`VSR_PORT_MONO_A, 8'hff);
		chk_rd(`VSR_PORT_FEAT_RD, 8'h00, 8'h00);
		chk_rd(`VSR_PORT_ENABLE, 8'h00, 8'h00);
		chk_rd(`VSR_PORT_DATA, 8'h0f, 8'h05);
		chk_rd(`VSR_PORT_DATA, 8'h0f, 8'h05);
		$display("test register access done");
		for (int m = 0; m < 7; m++)
		begin
			clk_mode(MODE[m]);
			seq_rd(`VSR_IDX_CLOCK, 8'h3d, MODE[m]);
			gap(1'b0, g);
			`CHK(g, CGAP[m])
			gap(1'b1, g);
			gap(1'b1, g);
			`CHK(g, SGAP[m])
		end
		$display("test clocking modes done");
		seq_wr(`VSR_IDX_RESET, 8'h02);
		tick(2);
		`CHK(SEQ_RUNNING, 1'b0)
		`CHK(CHAR_CLK_EN, 1'b0)
		seq_wr(`VSR_IDX_RESET, 8'h03);
		tick(3);
		`CHK(SEQ_RUNNING, 1'b1)
		seq_wr(`VSR_IDX_RESET, 8'h01);
		tick(20);
		`CHK(SEQ_RUNNING, 1'b0)
		gap(1'b0, g);
		`CHK(g, 200)
		clk_mode(8'h20);
		tick(2);
		`CHK(SCREEN_BLANK, 1'b1)
		`CHK(HOST_PRIORITY, 1'b1)
		gap(1'b0, g);
		`CHK(g, 9)
		$display("test halt and blank done");
		clk_mode(8'h00);
		for (int c = 0; c < 4; c++)
		begin
			GLYPH_CODE = CODE[c];
			tick(2);
			`CHK(NINTH_DOT, NINE[c])
		end
		GLYPH_CODE = 8'hc0;
		LINE_GFX_EN = 1'b0;
		tick(2);
		`CHK(NINTH_DOT, 1'b0)
		LINE_GFX_EN = 1'b1;
		DOT_EIGHT = 1'b0;
		tick(2);
		`CHK(NINTH_DOT, 1'b0)
		DOT_EIGHT = 1'b1;
		clk_mode(8'h01);
		tick(2);
		`CHK(NINTH_DOT, 1'b0)
		$display("test ninth dot done");
		for (int s = 0; s < 4; s++)
		begin
			halt_sync();
			CLOCK_SEL = s[1:0];
			seq_wr(`VSR_IDX_RESET, 8'h03);
			chk_rd(`VSR_PORT_ISR0, 8'h10, {3'h0, SENSE_SW[s], 4'h0});
		end
		RETRACE_IRQ_ENABLE = 1'b1;
		IN_VERTICAL_RETRACE = 1'b1;
		DISPLAY_ENABLE = 1'b0;
		PORT_BASE_SELECT = 1'b1;
		tick(3);
		`CHK(RETRACE_IRQ_PENDING, 1'b1)
		chk_rd(`VSR_PORT_ISR0, 8'h80, 8'h80);
		chk_rd(`VSR_PORT_COLOR_A, 8'h09, 8'h09);
		io_rd(`VSR_PORT_MONO_A);
		`CHK(rv, 1'b0)
		RETRACE_IRQ_CLEAR = 1'b1;
		tick(1);
		RETRACE_IRQ_CLEAR = 1'b0;
		tick(3);
		`CHK(RETRACE_IRQ_PENDING, 1'b0)
		chk_rd(`VSR_PORT_ISR0, 8'h80, 8'h00);
		IN_VERTICAL_RETRACE = 1'b0;
		DISPLAY_ENABLE = 1'b1;
		RETRACE_IRQ_ENABLE = 1'b0;
		PORT_BASE_SELECT = 1'b0;
		tick(2);
		IN_VERTICAL_RETRACE = 1'b1;
		tick(3);
		`CHK(RETRACE_IRQ_PENDING, 1'b0)
		IN_VERTICAL_RETRACE = 1'b0;
		tick(2);
		chk_rd(`VSR_PORT_MONO_A, 8'h09, 8'h00);
		io_rd(`VSR_PORT_COLOR_A);
		`CHK(rv, 1'b0)
		RETRACE_IRQ_ENABLE = 1'b1;
		RETRACE_IRQ_CLEAR = 1'b1;
		IN_VERTICAL_RETRACE = 1'b1;
		tick(1);
		RETRACE_IRQ_CLEAR = 1'b0;
		RETRACE_IRQ_ENABLE = 1'b0;
		IN_VERTICAL_RETRACE = 1'b0;
		tick(1);
		`CHK(RETRACE_IRQ_PENDING, 1'b1)
		$display("test status ports done");
		seq_wr(`VSR_IDX_MASK, 8'h03);
		MEM_WDATA = 8'ha7;
		mem_wr(1'b0);
		`CHK(PLANE_WE, 4'h3)
		`CHK(PLANE_WDATA, 32'ha7a7_a7a7)
		`CHK(PLANE_SRC_LATCH, 1'b0)
		tick(1);
		`CHK(PLANE_WE, 4'h0)
		seq_wr(`VSR_IDX_MASK, 8'h0f);
		LATCH_DATA = 32'h1234_abcd;
		mem_wr(1'b1);
		`CHK(PLANE_WE, 4'hf)
		`CHK(PLANE_SRC_LATCH, 1'b1)
		`CHK(PLANE_WDATA, 32'h1234_abcd)
		$display("test plane writes done");
		end_sim();
	end
endmodule : vsr_regs_bench
